// ### hw/vgr_map.svh
// Register offsets, field positions, reset values and line limits of the vertical gate block.
`ifndef VGR_MAP_SVH
`define VGR_MAP_SVH

// ----------------------------------------------------------------------------
// Register subaddresses
// ----------------------------------------------------------------------------
`define VGR_ADDR_START_LO 8'h15
`define VGR_ADDR_STOP_LO 8'h16
`define VGR_ADDR_MISC 8'h17
`define VGR_ADDR_GAIN 8'h18
`define VGR_ADDR_OFFSET 8'h19

// ----------------------------------------------------------------------------
// Bit positions in the miscellaneous register
// ----------------------------------------------------------------------------
`define VGR_MISC_START_MSB 0
`define VGR_MISC_STOP_MSB 1
`define VGR_MISC_EARLY 2
`define VGR_MISC_HALF_DIS 6
`define VGR_MISC_LINE_DIS 7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define VGR_RST_POS 8'h00
`define VGR_RST_MISC 8'h00
`define VGR_RST_GAIN 8'h80
`define VGR_RST_OFFSET 8'h80
`define VGR_RST_LINE 9'h000
`define VGR_READ_ZERO 8'h00

// ----------------------------------------------------------------------------
// Line counter limits and raw data scaling
// ----------------------------------------------------------------------------
`define VGR_MAX_50HZ 9'h138
`define VGR_MAX_60HZ 9'h106
`define VGR_LINE_STEP 9'h001
`define VGR_GAIN_SHIFT 7
`define VGR_OFFSET_BIAS 11'h080
`define VGR_RAW_MAX 11'h0FF
`define VGR_RAW_FULL 8'hFF
`define VGR_RAW_ZERO 8'h00

`endif

// ### hw/vgr_pkg.sv
// State types of the vertical gate and raw gain block.
package vgr_pkg;

  // Whole state of the top module.
  typedef struct packed {
    logic [7:0] start_lo;
    logic [7:0] stop_lo;
    logic [7:0] misc;
    logic [7:0] gain;
    logic [7:0] offset;
    logic [8:0] line_cnt;
    logic cnt_new;
    logic gate;
    logic field_identifier;
    logic [7:0] rdata;
  } vgr_top_state_t;

  // Whole state of the raw data scaler.
  typedef struct packed {
    logic [7:0] data;
    logic valid;
  } vgr_raw_state_t;

endpackage

// ### hw/vgr_raw_scale.sv
// Raw ADC bypass data scaler: linear gain, biased offset and clamping.
`timescale 1ns/100ps
`include "vgr_map.svh"

module vgr_raw_scale
  import vgr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic [7:0] gain_in,
  input wire logic [7:0] offset_in,
  input wire logic [7:0] data_in,
  input wire logic valid_in,
  output logic [7:0] data_out,
  output logic valid_out
);

  vgr_raw_state_t s;
  vgr_raw_state_t next_s;
  logic [15:0] product;
  logic [8:0] scaled;
  logic signed [10:0] sum;

  // Gain 128 is unity, so the product is divided by 128; the offset code is biased by 128.
  always_comb begin
    product = 16'(data_in) * 16'(gain_in); // RULE7
    scaled = product[15:`VGR_GAIN_SHIFT]; // RULE7
    sum = $signed({2'b00, scaled} + {3'b000, offset_in} - `VGR_OFFSET_BIAS); // RULE8
    next_s = s;
    next_s.valid = valid_in;
    if (valid_in) begin
      // Clamp rather than wrap, so doubled bright samples stay white.
      if (sum < 0) begin
        next_s.data = `VGR_RAW_ZERO;
      end else if (sum > $signed(`VGR_RAW_MAX)) begin
        next_s.data = `VGR_RAW_FULL;
      end else begin
        next_s.data = sum[7:0];
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign data_out = s.data;
  assign valid_out = s.valid;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  a_gain_off_zero: assert property ( // RULE7
    valid_in && gain_in == 8'h00 && offset_in == 8'h80 |=> data_out == 8'h00 && valid_out)
    else $error("Gain code zero did not switch the signal off.");
  a_gain_nominal: assert property ( // RULE7
    valid_in && gain_in == 8'h80 && offset_in == 8'h80 |=> data_out == $past(data_in))
    else $error("Nominal gain changed the sample.");
  a_gain_double: assert property ( // RULE7
    valid_in && gain_in == 8'hFF && offset_in == 8'h80 && data_in == 8'h40
    |=> data_out == 8'h7F)
    else $error("Full gain code did not double the sample.");
  a_offset_range: assert property ( // RULE8
    valid_in && gain_in == 8'h00 |=> data_out == (($past(offset_in) < 8'h80) ? 8'h00
      : $past(offset_in) - 8'h80))
    else $error("Offset code bias of 128 not applied.");
  c_raw_clamp: cover property (valid_in && gain_in == 8'hFF && data_in == 8'hFF);
endmodule

// ### hw/vgr_top.sv
// Vertical gate timing, field identifier, line clock output enables and raw data level control.
`timescale 1ns/100ps
`include "vgr_map.svh"

// What this block does
// RULE1: Gate rises when line count equals start.
// RULE2: Field identifier changes polarity at start line.
// RULE3: Start is eight low bits plus misc bit 0.
// RULE4: Gate falls at stop; stop MSB misc bit 1.
// RULE5: Early bit moves gate one line earlier, field two.
// RULE6: Misc bits 7 and 6 tri-state the clocks.
// RULE7: Raw gain: 0 off, 128 nominal, 255 double.
// RULE8: Raw offset biased 128: -128 to +128 LSB; the code reaches +127 at most.
// RULE9: Line values map per 50 or 60 Hz.
module vgr_top
  import vgr_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic line_strobe_in,
  input wire logic field_sync_in,
  input wire logic field2_in,
  input wire logic mode_60hz_in,
  input wire logic [7:0] raw_data_in,
  input wire logic raw_valid_in,
  output logic vertical_gate_pulse_out,
  output logic field_identifier_out,
  output logic line_clock_oe_n_out,
  output logic half_line_clock_oe_n_out,
  output logic [7:0] raw_data_out,
  output logic raw_valid_out
);

  // ----------------------------------------------------------------------------
  // State and decoded fields
  // ----------------------------------------------------------------------------
  vgr_top_state_t s;
  vgr_top_state_t next_s;
  logic [8:0] start_pos;
  logic [8:0] stop_pos;
  logic [8:0] line_max;
  logic [8:0] eff_line;
  logic early_now;

  // The nine-bit positions are always rebuilt from the live registers.
  assign start_pos = {s.misc[`VGR_MISC_START_MSB], s.start_lo}; // RULE3
  assign stop_pos = {s.misc[`VGR_MISC_STOP_MSB], s.stop_lo}; // RULE4
  assign line_max = mode_60hz_in ? `VGR_MAX_60HZ : `VGR_MAX_50HZ; // RULE9
  assign early_now = s.misc[`VGR_MISC_EARLY] & field2_in; // RULE5

  // Comparing against count plus one fires a line sooner without touching the
  // programmed positions; a start of zero is therefore never matched in an early field.
  assign eff_line = early_now ? s.line_cnt + `VGR_LINE_STEP : s.line_cnt; // RULE5

  // ----------------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------------
  always_comb begin
    next_s = s;

    // Register writes land one edge after the strobe.
    if (reg_wr_in) begin
      case (reg_addr_in)
        `VGR_ADDR_START_LO: begin
          next_s.start_lo = reg_wdata_in; // RULE3
        end
        `VGR_ADDR_STOP_LO: begin
          next_s.stop_lo = reg_wdata_in; // RULE4
        end
        `VGR_ADDR_MISC: begin
          next_s.misc = reg_wdata_in; // RULE6
        end
        `VGR_ADDR_GAIN: begin
          next_s.gain = reg_wdata_in;
        end
        `VGR_ADDR_OFFSET: begin
          next_s.offset = reg_wdata_in;
        end
        default: begin
          next_s.misc = s.misc; // Unmapped writes are dropped.
        end
      endcase
    end

    // Reads return the stored byte; an unmapped subaddress reads as zero.
    if (reg_rd_in) begin
      case (reg_addr_in)
        `VGR_ADDR_START_LO: begin
          next_s.rdata = s.start_lo;
        end
        `VGR_ADDR_STOP_LO: begin
          next_s.rdata = s.stop_lo;
        end
        `VGR_ADDR_MISC: begin
          next_s.rdata = s.misc;
        end
        `VGR_ADDR_GAIN: begin
          next_s.rdata = s.gain;
        end
        `VGR_ADDR_OFFSET: begin
          next_s.rdata = s.offset;
        end
        default: begin
          next_s.rdata = `VGR_READ_ZERO;
        end
      endcase
    end

    // Value zero is the first counted line of a field; the count holds at the
    // last value of the standard so a missing field sync cannot wrap it.
    if (field_sync_in) begin
      next_s.line_cnt = `VGR_RST_LINE; // RULE9
    end else if (line_strobe_in && s.line_cnt < line_max) begin
      next_s.line_cnt = s.line_cnt + `VGR_LINE_STEP; // RULE9
    end
    next_s.cnt_new = field_sync_in | line_strobe_in;

    // Compare once per new line value; stop wins when both match.
    if (s.cnt_new) begin
      if (eff_line == stop_pos) begin
        next_s.gate = 1'b0; // RULE4
      end else if (eff_line == start_pos) begin
        next_s.gate = 1'b1; // RULE1 RULE5
      end
      // The identifier follows the unshifted start position.
      if (s.line_cnt == start_pos) begin
        next_s.field_identifier = field2_in; // RULE2
      end
    end
  end

  // ----------------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s.start_lo <= `VGR_RST_POS;
      s.stop_lo <= `VGR_RST_POS;
      s.misc <= `VGR_RST_MISC;
      s.gain <= `VGR_RST_GAIN;
      s.offset <= `VGR_RST_OFFSET;
      s.line_cnt <= `VGR_RST_LINE;
      s.cnt_new <= 1'b0;
      s.gate <= 1'b0;
      s.field_identifier <= 1'b0;
      s.rdata <= `VGR_READ_ZERO;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  // The enables are active low: a set disable bit releases the clock pin.
  assign line_clock_oe_n_out = s.misc[`VGR_MISC_LINE_DIS]; // RULE6
  assign half_line_clock_oe_n_out = s.misc[`VGR_MISC_HALF_DIS]; // RULE6
  assign vertical_gate_pulse_out = s.gate;
  assign field_identifier_out = s.field_identifier;
  assign reg_rdata_out = s.rdata;

  // Raw bypass samples see the gain and offset registers directly, so a new
  // setting takes effect on the very next sample; the host must time its writes.
  vgr_raw_scale u_raw (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .gain_in(s.gain),
    .offset_in(s.offset),
    .data_in(raw_data_in),
    .valid_in(raw_valid_in),
    .data_out(raw_data_out),
    .valid_out(raw_valid_out)
  );

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  // Every check runs on the system clock and rests while reset is held.
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  a_gate_rise_start: assert property ( // RULE1
    s.cnt_new && !early_now && s.line_cnt == start_pos && s.line_cnt != stop_pos
    |=> vertical_gate_pulse_out)
    else $error("Gate did not rise at the start line.");

  a_fid_at_start: assert property ( // RULE2
    s.cnt_new && s.line_cnt == start_pos |=> field_identifier_out == $past(field2_in))
    else $error("Field identifier did not follow the field at the start line.");

  a_start_msb_write: assert property ( // RULE3
    reg_wr_in && reg_addr_in == `VGR_ADDR_MISC
    |=> start_pos[8] == $past(reg_wdata_in[0]) && stop_pos[8] == $past(reg_wdata_in[1]))
    else $error("Position MSBs not taken from misc bits 0 and 1.");

  a_gate_fall_stop: assert property ( // RULE4
    s.cnt_new && eff_line == stop_pos |=> !vertical_gate_pulse_out ##1
    (vertical_gate_pulse_out == $past(vertical_gate_pulse_out) || $past(s.cnt_new)))
    else $error("Gate did not fall at the stop line.");

  a_gate_early: assert property ( // RULE5
    s.cnt_new && early_now && s.line_cnt + 9'h001 == start_pos && eff_line != stop_pos
    |=> vertical_gate_pulse_out)
    else $error("Gate did not rise one line early in field two.");

  a_gate_steady: assert property ( // RULE1
    !s.cnt_new && !rst_in |=> $stable(vertical_gate_pulse_out))
    else $error("Gate moved without a new line.");

  // A low gate may only rise on a line whose compared count meets the start.
  a_gate_no_stray: assert property ( // RULE1
    s.cnt_new && eff_line != start_pos && !vertical_gate_pulse_out |=> !vertical_gate_pulse_out)
    else $error("Gate rose away from the start line.");

  // A high gate may only fall on a stop match.
  a_gate_no_drop: assert property ( // RULE4
    s.cnt_new && eff_line != stop_pos && vertical_gate_pulse_out |=> vertical_gate_pulse_out)
    else $error("Gate fell away from the stop line.");

  // The early option also pulls the falling edge one line forward.
  a_early_stop: assert property ( // RULE5
    s.cnt_new && early_now && s.line_cnt + 9'h001 == stop_pos |=> !vertical_gate_pulse_out)
    else $error("Gate did not fall one line early in field two.");

  // In field one the early bit must leave the start line where it is.
  a_early_field_one: assert property ( // RULE5
    s.cnt_new && s.misc[`VGR_MISC_EARLY] && !field2_in && s.line_cnt == start_pos
    && s.line_cnt != stop_pos |=> vertical_gate_pulse_out)
    else $error("Early option moved the gate in field one.");

  // The identifier may only move on the unshifted start line.
  a_fid_steady: assert property ( // RULE2
    !(s.cnt_new && s.line_cnt == start_pos) |=> $stable(field_identifier_out))
    else $error("Field identifier moved away from the start line.");

  a_clock_enables: assert property ( // RULE6
    reg_wr_in && reg_addr_in == `VGR_ADDR_MISC
    |=> line_clock_oe_n_out == $past(reg_wdata_in[7])
        && half_line_clock_oe_n_out == $past(reg_wdata_in[6]))
    else $error("Clock output enables do not follow misc bits 7 and 6.");

  // ----------------------------------------------------------------------------
  // Register port checks
  // ----------------------------------------------------------------------------
  // Low bytes land whole; the MSBs stay in the misc register.
  a_start_low_write: assert property ( // RULE3
    reg_wr_in && reg_addr_in == `VGR_ADDR_START_LO |=> start_pos[7:0] == $past(reg_wdata_in))
    else $error("Start low byte not taken from its register.");

  a_stop_low_write: assert property ( // RULE4
    reg_wr_in && reg_addr_in == `VGR_ADDR_STOP_LO |=> stop_pos[7:0] == $past(reg_wdata_in))
    else $error("Stop low byte not taken from its register.");

  // The level settings reach the raw path one edge after the write.
  a_gain_write: assert property ( // RULE7
    reg_wr_in && reg_addr_in == `VGR_ADDR_GAIN |=> s.gain == $past(reg_wdata_in))
    else $error("Gain setting not stored.");

  a_offset_write: assert property ( // RULE8
    reg_wr_in && reg_addr_in == `VGR_ADDR_OFFSET |=> s.offset == $past(reg_wdata_in))
    else $error("Offset setting not stored.");

  // Read data stands until the next read, so a slow host may fetch it late.
  a_read_hold: assert property (
    !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("Read data changed without a read.");

  // ----------------------------------------------------------------------------
  // Line counter checks
  // ----------------------------------------------------------------------------

  a_line_zero_sync: assert property ( // RULE9
    field_sync_in |=> s.line_cnt == 9'h000 && s.cnt_new)
    else $error("Field sync did not restart the line count.");

  a_line_hold_max: assert property ( // RULE9
    line_strobe_in && !field_sync_in && s.line_cnt >= line_max
    |=> s.line_cnt == $past(s.line_cnt))
    else $error("Line count passed the last value of the standard.");

  // Below the ceiling each strobe adds exactly one line.
  a_line_step: assert property ( // RULE9
    line_strobe_in && !field_sync_in && s.line_cnt < line_max
    |=> s.line_cnt == $past(s.line_cnt) + 9'h001)
    else $error("Line strobe did not advance the count by one.");

  // Without a strobe the count must rest, or a compare could fire twice.
  a_line_steady: assert property ( // RULE9
    !line_strobe_in && !field_sync_in |=> $stable(s.line_cnt))
    else $error("Line count moved without a strobe.");

  // ----------------------------------------------------------------------------
  // Decode and raw path checks
  // ----------------------------------------------------------------------------

  a_unmapped_read: assert property (
    reg_rd_in && (reg_addr_in < `VGR_ADDR_START_LO || reg_addr_in > `VGR_ADDR_OFFSET)
    |=> reg_rdata_out == 8'h00)
    else $error("Unmapped subaddress did not read as zero.");

  // Each raw sample leaves with its qualifier one edge later.
  a_raw_valid_copy: assert property ( // RULE7
    raw_valid_in |=> raw_valid_out)
    else $error("Raw sample qualifier was lost.");

  // Main scenarios: a rising gate, a new field, an early gate, both clocks released.
  c_gate_rise: cover property (!vertical_gate_pulse_out ##1 vertical_gate_pulse_out);
  c_fid_toggle: cover property ($changed(field_identifier_out));
  c_early_gate: cover property (early_now && s.cnt_new && eff_line == start_pos);
  c_clock_tristate: cover property (line_clock_oe_n_out && half_line_clock_oe_n_out);
endmodule

// ### test/vgr_top_tb_top.sv
// Self-checking testbench of the vertical gate and raw data level block.
`timescale 1ns/100ps
`include "vgr_map.svh"

module vgr_top_tb_top;
  // --------------------------------------------------------------------------
  // Signals and bookkeeping
  // --------------------------------------------------------------------------
  logic clk_sys_in, rst_in, reg_wr_in, reg_rd_in, line_strobe_in, field_sync_in;
  logic field2_in, mode_60hz_in, raw_valid_in, raw_valid_out;
  logic vertical_gate_pulse_out, field_identifier_out;
  logic line_clock_oe_n_out, half_line_clock_oe_n_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, raw_data_in, raw_data_out;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int cnt = 0;
  int cur_start = 0;
  int cur_stop = 0;
  logic cur_early = 1'b0;
  logic exp_gate = 1'b0;
  logic exp_fid = 1'b0;
  logic rd_pend = 1'b0;
  logic [7:0] rd_q[$];
  logic [7:0] raw_q[$];
  logic gate_q[$];
  logic fid_q[$];
  logic ln_p1 = 1'b0;
  logic ln_p2 = 1'b0;
  int gains[3] = '{0, 128, 255};

  vgr_top i_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out), .line_strobe_in(line_strobe_in),
    .field_sync_in(field_sync_in), .field2_in(field2_in), .mode_60hz_in(mode_60hz_in),
    .raw_data_in(raw_data_in), .raw_valid_in(raw_valid_in),
    .vertical_gate_pulse_out(vertical_gate_pulse_out),
    .field_identifier_out(field_identifier_out),
    .line_clock_oe_n_out(line_clock_oe_n_out),
    .half_line_clock_oe_n_out(half_line_clock_oe_n_out),
    .raw_data_out(raw_data_out), .raw_valid_out(raw_valid_out)
  );

  // Free-running system clock at 100 MHz.
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  // Compares one value; one-bit flags are passed zero-extended so X still fails.
  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask

  // The expected byte is queued now and judged by the watcher when it returns.
  task automatic rd(input logic [7:0] a, input logic [7:0] want);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    rd_q.push_back(want);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
  endtask

  // One line or field start; strobes are three cycles apart, above the two-cycle minimum.
  // The expected gate and identifier are queued for the watcher to judge later.
  task automatic strobe(input logic sync);
    int eff;
    @(posedge clk_sys_in);
    if (sync) field_sync_in <= 1'b1;
    else line_strobe_in <= 1'b1;
    @(posedge clk_sys_in);
    field_sync_in <= 1'b0;
    line_strobe_in <= 1'b0;
    if (sync) cnt = 0;
    else if (cnt < (mode_60hz_in ? 262 : 312)) cnt++;
    eff = (cur_early && field2_in) ? cnt + 1 : cnt;
    if (eff == cur_stop) exp_gate = 1'b0;
    else if (eff == cur_start) exp_gate = 1'b1;
    if (cnt == cur_start) exp_fid = field2_in;
    gate_q.push_back(exp_gate);
    fid_q.push_back(exp_fid);
    @(posedge clk_sys_in);
  endtask

  // Programs 9-bit positions and runs one field of the given length.
  task automatic field(input int start, input int stop, input int lines,
                       input logic f2, input logic early, input logic m60);
    logic [8:0] s9;
    logic [8:0] p9;
    logic [7:0] misc;
    s9 = 9'(start);
    p9 = 9'(stop);
    misc = {5'h00, early, p9[8], s9[8]};
    wr(`VGR_ADDR_START_LO, s9[7:0]);
    wr(`VGR_ADDR_STOP_LO, p9[7:0]);
    wr(`VGR_ADDR_MISC, misc);
    rd(`VGR_ADDR_MISC, misc);
    @(posedge clk_sys_in);
    field2_in <= f2;
    mode_60hz_in <= m60;
    cur_start = start;
    cur_stop = stop;
    cur_early = early;
    strobe(1'b1);
    repeat (lines) strobe(1'b0);
  endtask

  // Streams back-to-back samples at one gain and offset setting.
  task automatic raw(input int g, input int o, input int n);
    int d;
    int x;
    wr(`VGR_ADDR_GAIN, 8'(g));
    wr(`VGR_ADDR_OFFSET, 8'(o));
    repeat (n) begin
      d = $urandom % 256;
      x = ((d * g) >> 7) + o - 128;
      x = (x < 0) ? 0 : ((x > 255) ? 255 : x);
      @(posedge clk_sys_in);
      raw_data_in <= 8'(d);
      raw_valid_in <= 1'b1;
      raw_q.push_back(8'(x));
    end
    @(posedge clk_sys_in);
    raw_valid_in <= 1'b0;
  endtask

  // --------------------------------------------------------------------------
  // Result watcher and timeout
  // --------------------------------------------------------------------------
  // Outputs are read at the edge, so they hold what the previous edge launched.
  always @(posedge clk_sys_in) begin
    cycles++;
    if (rd_pend) begin
      if (rd_q.size() == 0) check(8'h00, 8'h01, "unexpected read");
      else check(reg_rdata_out, rd_q.pop_front(), "read data");
    end
    rd_pend <= reg_rd_in;
    // A strobe taken at one edge is compared at the next and shows one edge later.
    if (ln_p2 && gate_q.size() == 0) check(8'h00, 8'h01, "unexpected line");
    if (ln_p2 && gate_q.size() != 0) begin
      check(8'(vertical_gate_pulse_out), 8'(gate_q.pop_front()), "gate");
      check(8'(field_identifier_out), 8'(fid_q.pop_front()), "field id");
    end
    ln_p2 <= ln_p1;
    ln_p1 <= line_strobe_in | field_sync_in;
    if (raw_valid_out === 1'b1) begin
      if (raw_q.size() == 0) check(8'h00, 8'h01, "unexpected sample");
      else check(raw_data_out, raw_q.pop_front(), "raw sample");
    end
    if (cycles == 6000) begin
      n_errors++;
      $display("BAD %0t timeout", $time);
      stop_test();
    end
  end

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    rst_in = 1'b1;
    {reg_wr_in, reg_rd_in, line_strobe_in, field_sync_in} = 4'h0;
    {field2_in, mode_60hz_in, raw_valid_in} = 3'h0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 8'h00;
    raw_data_in = 8'h00;
    void'($urandom(32'h4c69));
    repeat (5) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    rd(`VGR_ADDR_START_LO, 8'h00);
    rd(`VGR_ADDR_STOP_LO, 8'h00);
    rd(`VGR_ADDR_MISC, 8'h00);
    rd(`VGR_ADDR_GAIN, 8'h80);
    rd(`VGR_ADDR_OFFSET, 8'h80);
    // Unmapped places neither store nor return anything.
    wr(8'h1A, 8'h5A);
    rd(8'h1A, 8'h00);
    rd(8'h14, 8'h00);
    // Every combination of the two clock output disables.
    for (int v = 0; v < 4; v++) begin
      wr(`VGR_ADDR_MISC, 8'(v << 6));
      @(posedge clk_sys_in);
      check({7'h00, line_clock_oe_n_out}, 8'(v >> 1), "line clock oe");
      check({7'h00, half_line_clock_oe_n_out}, 8'(v & 1), "half clock oe");
    end
    // Plain, early second field, 60 Hz with MSBs and the early bit in field one,
    // and 50 Hz saturation.
    field(5, 8, 12, 1'b0, 1'b0, 1'b0);
    field(5, 8, 12, 1'b1, 1'b1, 1'b0);
    field(260, 262, 265, 1'b0, 1'b1, 1'b1);
    field(312, 2, 316, 1'b1, 1'b0, 1'b0);
    // Documented gain and offset codes, then random settings.
    foreach (gains[i]) foreach (gains[j]) raw(gains[i], gains[j], 4);
    repeat (6) raw($urandom % 256, $urandom % 256, 8);
    // Release both clock pins, then a mid-run reset must restore the gate, identifier, clock enables and misc, gain and offset registers.
    wr(`VGR_ADDR_MISC, 8'hC1);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    check(8'(vertical_gate_pulse_out), 8'h00, "gate after reset");
    check(8'(field_identifier_out), 8'h00, "field id after reset");
    check(8'(line_clock_oe_n_out), 8'h00, "line clock oe after reset");
    check(8'(half_line_clock_oe_n_out), 8'h00, "half clock oe after reset");
    rd(`VGR_ADDR_MISC, 8'h00);
    rd(`VGR_ADDR_GAIN, 8'h80);
    rd(`VGR_ADDR_OFFSET, 8'h80);
    repeat (4) @(posedge clk_sys_in);
    if (rd_q.size() != 0 || raw_q.size() != 0 || gate_q.size() != 0) begin
      n_errors++;
      $display("BAD %0t results missing", $time);
    end
    stop_test();
  end
endmodule
